//--- logic/msqr_pkg.sv
// constants, codes and carrier types of the motor state query responder
package msqr_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CMD       = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_STATE     = 8'h08;
    localparam logic [7:0] OFS_PINS      = 8'h0C;
    localparam logic [7:0] OFS_FREE      = 8'h10;
    localparam logic [7:0] OFS_SPEED     = 8'h14;
    localparam logic [7:0] OFS_MSPEED    = 8'h18;
    localparam logic [7:0] OFS_ANSWER    = 8'h20;
    localparam int         ANS_WORDS     = 8;
    localparam int         ANS_BYTES     = 4 * ANS_WORDS;
    // status register field positions
    localparam int ST_VALID   = 0;
    localparam int ST_ALARM   = 1;
    localparam int ST_IGNORED = 2;
    localparam int ST_LEN_LO  = 8;
    // state flag word bit positions
    localparam int SF_CMD_ERR   = 0;
    localparam int SF_DATA_ERR  = 1;
    localparam int SF_VALUE_ERR = 2;
    localparam int SF_ALARM     = 6;
    localparam int SF_MOTOR_LO  = 18;
    // command codes, four characters least significant byte first
    localparam logic [31:0] CMD_FW_VERSION = 32'h7677_6667;
    localparam logic [31:0] CMD_GO_FW      = 32'h7766_6F67;
    localparam logic [31:0] CMD_POSITION   = 32'h736F_7067;
    // answer lengths in bytes
    localparam logic [4:0] LEN_ECHO = 5'd4;
    localparam logic [4:0] LEN_FWV  = 5'd10;
    localparam logic [4:0] LEN_GOFW = 5'd15;
    localparam logic [4:0] LEN_POS  = 5'd26;
    // reset value of the state registers
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // monitor levels from logic on the same clock
    typedef struct packed {
        logic       positionControlError;
        logic       driverOverheat;
        logic       controllerOverheat;
        logic       supplyOvervoltage;
        logic       supplyOvercurrent;
        logic       busOvervoltage;
        logic       busUndervoltage;
        logic       busOvercurrent;
        logic       wrongEdge;
        logic       supplyUndervoltage;
        logic       bridgeFault;
        logic       windingMismatch;
        logic       encoderFault;
        logic       motorCurrentLimit;
    } msqr_fault_t;

    // asynchronous pin levels
    typedef struct packed {
        logic       rightEdge;
        logic       leftEdge;
        logic       buttonRight;
        logic       buttonLeft;
        logic       auxLevel;
        logic       brake;
        logic       revolutionSensor;
        logic       syncInput;
        logic       quadA;
        logic       quadB;
    } msqr_pins_t;

    // motion values from the motion core, same clock
    typedef struct packed {
        logic [31:0] position;
        logic [15:0] microstepPart;
        logic [63:0] encoderCount;
        logic [31:0] speed;
        logic [15:0] microSpeed;
    } msqr_motion_t;
endpackage

//--- logic/msqr_responder.sv
// apb command responder answering state, version, jump and position queries
//
// Implementation choices: the register addresses and the APB register port.
module msqr_responder
#(
    parameter logic [31:0] CMD_STOP        = 32'h706F_7473, // stop code
    parameter logic [31:0] CMD_STATE       = 32'h7374_6567, // state query
    parameter logic [7:0]  RESULT_OK       = 8'h00,
    parameter logic [7:0]  RESULT_NO_FW    = 8'h01,
    parameter logic [7:0]  RESULT_RUNNING  = 8'h02
)
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic [7:0]            paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire msqr_pkg::msqr_fault_t faults,
    input  wire msqr_pkg::msqr_pins_t  pins,
    input  wire msqr_pkg::msqr_motion_t motion,
    input  wire logic [1:0]            motorSelect,
    input  wire logic                  auxDirOut,
    input  wire logic                  syncOutLevel,
    input  wire logic [7:0]            queueFreeCells,
    input  wire logic [7:0]            fwMajor,
    input  wire logic [7:0]            fwMinor,
    input  wire logic [15:0]           fwRelease,
    input  wire logic                  hasFirmware,
    input  wire logic                  inFirmware,
    input  wire logic                  dangerEvent,
    input  wire logic                  integrityError,
    input  wire logic                  valueError,
    output logic                       alarm,
    output logic                       stopRequest,
    output logic                       jumpToFirmware
);
    import msqr_pkg::*;

    // address is word aligned and hits a register or an answer word
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00)
               && (a <= OFS_MSPEED
                   || (a >= OFS_ANSWER
                       && a < OFS_ANSWER + 8'(ANS_BYTES)));
    endfunction

    msqr_pins_t      pinMeta;      // first synchroniser stage
    msqr_pins_t      pinSync;      // second stage, safe to read
    logic [31:0]     stateWord;    // snapshot of the state flag word
    logic [31:0]     pinWord;      // snapshot of the pin state word
    logic [7:0]      freeSnap;     // snapshot of free queue cells
    logic [31:0]     speedSnap;    // snapshot of speed
    logic [15:0]     mspeedSnap;   // snapshot of microstep speed
    logic [31:0]     lastCode;     // last accepted command code
    logic [31:0]     ansWord [ANS_WORDS]; // answer buffer
    logic [4:0]      ansLen;       // answer length in bytes
    logic            ansValid;     // answer buffer holds an answer
    logic            ignored;      // last command dropped in alarm
    logic [2:0]      errFlags;     // sticky command, data, value errors
    logic            jumpPending;  // jump waits for answer read
    logic [31:0]     liveState;    // live state flag word
    logic [31:0]     livePins;     // live pin state word
    logic [7:0]      nb [ANS_BYTES]; // next answer bytes
    logic [4:0]      next_len;     // next answer length
    logic            knownCode;    // command code is recognised
    logic            allowed;      // command passes the alarm gate
    logic            setupRd;      // read setup cycle
    logic            access;       // apb access completes this edge
    logic            cmdTake;      // command code written
    logic            take;         // command accepted for execution
    logic            lastRead;     // final answer word read
    logic [2:0]      lastIdx;      // word holding the last answer byte

    // apb answers one cycle after setup, with no further wait
    assign pready  = psel & penable;
    assign access  = psel & penable;
    assign pslverr = psel & penable & ~mapped(paddr);
    assign setupRd = psel & ~penable & ~pwrite;
    assign cmdTake = access & pwrite & (paddr == OFS_CMD);
    assign lastIdx = 3'((ansLen - 5'd1) >> 2);
    assign lastRead = access & ~pwrite & ansValid
                    & (paddr == OFS_ANSWER + {3'b000, lastIdx, 2'b00});

    // recognised codes and alarm gate
    assign knownCode = (pwdata == CMD_STOP) || (pwdata == CMD_STATE)
                     || (pwdata == CMD_FW_VERSION)
                     || (pwdata == CMD_GO_FW)
                     || (pwdata == CMD_POSITION);
    // in alarm every command code except the jump command runs
    assign allowed = ~alarm || (pwdata != CMD_GO_FW);
    assign take    = cmdTake & allowed;

    // live state flag word built from monitors
    always_comb
    begin
        liveState               = RST_WORD;
        liveState[SF_VALUE_ERR:SF_CMD_ERR] = errFlags;
        liveState[SF_ALARM]     = alarm;
        liveState[7]            = faults.positionControlError;
        liveState[8]            = faults.driverOverheat;
        liveState[9]            = faults.controllerOverheat;
        liveState[10]           = faults.supplyOvervoltage;
        liveState[11]           = faults.supplyOvercurrent;
        liveState[12]           = faults.busOvervoltage;
        liveState[13]           = faults.busUndervoltage;
        liveState[14]           = faults.busOvercurrent;
        liveState[15]           = faults.wrongEdge;
        liveState[16]           = faults.supplyUndervoltage;
        liveState[17]           = faults.bridgeFault;
        liveState[SF_MOTOR_LO+1:SF_MOTOR_LO] = motorSelect;
        liveState[20]           = faults.windingMismatch;
        liveState[21]           = faults.encoderFault;
        liveState[22]           = faults.motorCurrentLimit;
    end

    // live pin state word, unused digital bits read zero
    always_comb
    begin
        livePins     = RST_WORD;
        livePins[0]  = pinSync.rightEdge;
        livePins[1]  = pinSync.leftEdge;
        livePins[2]  = pinSync.buttonRight;
        livePins[3]  = pinSync.buttonLeft;
        livePins[4]  = auxDirOut;
        livePins[5]  = pinSync.auxLevel;
        livePins[9]  = pinSync.brake;
        livePins[10] = pinSync.revolutionSensor;
        livePins[11] = pinSync.syncInput;
        livePins[12] = syncOutLevel;
        livePins[13] = pinSync.quadA;
        livePins[14] = pinSync.quadB;
    end

    // answer assembly, every field least significant byte first
    always_comb
    begin
        logic [15:0] sum;
        sum = 16'h0000;
        for (int i = 0; i < ANS_BYTES; i++)
        begin
            nb[i] = 8'h00;
        end
        for (int i = 0; i < 4; i++)
        begin
            nb[i] = pwdata[8*i +: 8];
        end
        next_len = LEN_ECHO;
        if (pwdata == CMD_FW_VERSION)
        begin
            // version answer: code, major, minor, release, checksum
            nb[4]    = fwMajor;
            nb[5]    = fwMinor;
            nb[6]    = fwRelease[7:0];
            nb[7]    = fwRelease[15:8];
            next_len = LEN_FWV;
        end
        else if (pwdata == CMD_GO_FW)
        begin
            // result byte then eight reserved bytes
            if (inFirmware)
                nb[4] = RESULT_RUNNING;
            else if (!hasFirmware)
                nb[4] = RESULT_NO_FW;
            else
                nb[4] = RESULT_OK;
            next_len = LEN_GOFW;
        end
        else if (pwdata == CMD_POSITION)
        begin
            // whole steps, microstep part, encoder count, six reserved
            for (int i = 0; i < 4; i++)
            begin
                nb[4 + i] = motion.position[8*i +: 8];
            end
            for (int i = 0; i < 2; i++)
            begin
                nb[8 + i] = motion.microstepPart[8*i +: 8];
            end
            for (int i = 0; i < 8; i++)
            begin
                nb[10 + i] = motion.encoderCount[8*i +: 8];
            end
            next_len = LEN_POS;
        end
        // checksum: 16-bit sum of the bytes after the code
        for (int i = 4; i < ANS_BYTES; i++)
        begin
            if (5'(i) < next_len - 5'd2)
                sum = sum + {8'h00, nb[i]};
        end
        if (next_len != LEN_ECHO)
        begin
            nb[next_len - 5'd2] = sum[7:0];
            nb[next_len - 5'd1] = sum[15:8];
        end
    end

    // two-flop synchroniser for pin levels
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pinMeta <= '0;
            pinSync <= '0;
        end
        else
        begin
            pinMeta <= pins;
            pinSync <= pinMeta;
        end
    end

    // alarm: set by danger, cleared by stop only, set wins
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            alarm <= 1'b0;
        else if (dangerEvent)
            alarm <= 1'b1;
        else if (cmdTake && pwdata == CMD_STOP)
            alarm <= 1'b0;
    end

    // sticky error flags, cleared by a state query, set wins
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            errFlags <= 3'b000;
        else
            errFlags <= ((take && pwdata == CMD_STATE) ? 3'b000 : errFlags)
                      | {valueError, integrityError,
                         cmdTake & ~knownCode};
    end

    // consistent snapshot of state, pins, cells and speed
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            stateWord  <= RST_WORD;
            pinWord    <= RST_WORD;
            freeSnap   <= 8'h00;
            speedSnap  <= RST_WORD;
            mspeedSnap <= 16'h0000;
        end
        else if (take && pwdata == CMD_STATE)
        begin
            // all values caught on the same edge
            stateWord  <= liveState;
            pinWord    <= livePins;
            freeSnap   <= queueFreeCells;
            speedSnap  <= motion.speed;
            mspeedSnap <= motion.microSpeed;
        end
    end

    // answer buffer and command bookkeeping
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int w = 0; w < ANS_WORDS; w++)
                ansWord[w] <= RST_WORD;
            ansLen   <= LEN_ECHO;
            ansValid <= 1'b0;
            ignored  <= 1'b0;
            lastCode <= RST_WORD;
        end
        else if (cmdTake)
        begin
            // dropped commands leave the previous answer in place
            ignored <= ~allowed;
            if (allowed)
            begin
                for (int w = 0; w < ANS_WORDS; w++)
                    ansWord[w] <= {nb[4*w+3], nb[4*w+2],
                                   nb[4*w+1], nb[4*w]};
                ansLen   <= next_len;
                ansValid <= 1'b1;
                lastCode <= pwdata;
            end
        end
    end
    // stop pulse to the motion core
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            stopRequest <= 1'b0;
        else
            stopRequest <= cmdTake && pwdata == CMD_STOP;
    end

    // jump armed by an ok answer, fired once it has been read
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            jumpPending    <= 1'b0;
            jumpToFirmware <= 1'b0;
        end
        else
        begin
            jumpToFirmware <= jumpPending & lastRead & ~cmdTake;
            if (take)
                jumpPending <= pwdata == CMD_GO_FW
                             && hasFirmware && !inFirmware;
            else if (lastRead)
                jumpPending <= 1'b0;
        end
    end

    // read data registered in the setup cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            prdata <= RST_WORD;
        else if (setupRd)
        begin
            prdata <= RST_WORD;
            if (paddr >= OFS_ANSWER && mapped(paddr))
                prdata <= ansWord[3'((paddr - OFS_ANSWER) >> 2)];
            else
            begin
                unique case (paddr)
                    OFS_CMD:    prdata <= lastCode;
                    OFS_STATUS: prdata <= {19'h0_0000, ansLen, 5'h00,
                                           ignored, alarm, ansValid};
                    OFS_STATE:  prdata <= stateWord;
                    OFS_PINS:   prdata <= pinWord;
                    OFS_FREE:   prdata <= {24'h00_0000, freeSnap};
                    OFS_SPEED:  prdata <= speedSnap;
                    OFS_MSPEED: prdata <= {16'h0000, mspeedSnap};
                    default:    prdata <= RST_WORD;
                endcase
            end
        end
    end
    // checks beside the logic
    chk_alarm_set: assert property (@(posedge ref_clk) disable iff (rst)
        dangerEvent |=> alarm)
        else $error("alarm not set after danger");
    chk_alarm_hold: assert property (@(posedge ref_clk) disable iff (rst)
        alarm && !(cmdTake && pwdata == CMD_STOP) |=> alarm)
        else $error("alarm cleared without stop");
    chk_alarm_stop: assert property (@(posedge ref_clk) disable iff (rst)
        cmdTake && pwdata == CMD_STOP && !dangerEvent
        |=> !alarm && stopRequest)
        else $error("stop did not clear alarm");
    chk_alarm_ignore: assert property (@(posedge ref_clk) disable iff (rst)
        alarm && cmdTake && pwdata == CMD_GO_FW
        |=> $stable(ansWord[0]) && ignored && !jumpPending)
        else $error("jump command ran during alarm");
    chk_fwv_length: assert property (@(posedge ref_clk) disable iff (rst)
        take && pwdata == CMD_FW_VERSION
        |=> ansLen == 5'd10 && ansWord[1][7:0] == $past(fwMajor))
        else $error("version answer malformed");
    chk_pos_length: assert property (@(posedge ref_clk) disable iff (rst)
        take && pwdata == CMD_POSITION
        |=> ansLen == 5'd26
            && ansWord[1] == $past(motion.position))
        else $error("position answer malformed");
    chk_jump_after: assert property (@(posedge ref_clk) disable iff (rst)
        jumpToFirmware |-> $past(lastRead) && $past(jumpPending))
        else $error("jump before answer was read");
    chk_jump_result: assert property (@(posedge ref_clk) disable iff (rst)
        take && pwdata == CMD_GO_FW && inFirmware
        |=> ansWord[1][7:0] == RESULT_RUNNING && !jumpPending)
        else $error("already running result wrong");
    chk_motor_field: assert property (@(posedge ref_clk) disable iff (rst)
        take && pwdata == CMD_STATE
        |=> stateWord[19:18] == $past(motorSelect)
            && pinWord[2] == $past(pinSync.buttonRight))
        else $error("snapshot fields wrong");
    chk_err_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        cmdTake && !knownCode |=> errFlags[0] [*2])
        else $error("command error not held");
endmodule // msqr_responder

//--- tb/msqr_host_model.sv
// apb host model that issues register transfers to the responder
module msqr_host_model
(
    input  wire logic        ref_clk,
    output logic      [7:0]  paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             hung
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {paddr, psel, penable, pwrite, pwdata, hung} = '0;
    end
    // setup, then access held until pready at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        // a slave that never answers ends the run
        hung = (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // msqr_host_model

//--- tb/motor_state_query_responder_bench.sv
// self-checking bench of the motor state query responder
module motor_state_query_responder_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import msqr_pkg::*;
    logic          ref_clk = 0, rst = 1;
    logic   [7:0]  paddr, queueFreeCells = 8'hA5, fwMajor = 8'h12;
    logic          psel, penable, pwrite, pready, pslverr, hung, rs;
    logic   [31:0] pwdata, prdata, rq;
    msqr_fault_t   faults = '0;
    msqr_pins_t    pins = '0;
    msqr_motion_t  motion = '0;
    logic   [1:0]  motorSelect = 2'd0;
    logic   [7:0]  fwMinor = 8'h34;
    logic   [15:0] fwRelease = 16'h5678;
    logic          auxDirOut = 0, syncOutLevel = 0, hasFirmware = 0;
    logic          inFirmware = 0, dangerEvent = 0, integrityError = 0;
    logic          valueError = 0, alarm, stopRequest, jumpToFirmware;
    int            errors = 0, n_compared = 0;
    // expected flag of each fault and pin input, lowest struct bit first
    logic   [31:0] fMask [14] = '{32'h40_0000, 32'h20_0000, 32'h10_0000,
        32'h2_0000, 32'h1_0000, 32'h8000, 32'h4000, 32'h2000, 32'h1000,
        32'h800, 32'h400, 32'h200, 32'h100, 32'h80};
    logic   [31:0] pMask [10] = '{32'h4000, 32'h2000, 32'h800, 32'h400,
        32'h200, 32'h20, 32'h8, 32'h4, 32'h2, 32'h1};

    always #50 ref_clk = ~ref_clk;

    msqr_host_model host (.ref_clk(ref_clk), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hung(hung));

    msqr_responder dut (.ref_clk(ref_clk), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .faults(faults), .pins(pins), .motion(motion),
        .motorSelect(motorSelect), .auxDirOut(auxDirOut),
        .syncOutLevel(syncOutLevel), .queueFreeCells(queueFreeCells),
        .fwMajor(fwMajor), .fwMinor(fwMinor), .fwRelease(fwRelease),
        .hasFirmware(hasFirmware), .inFirmware(inFirmware),
        .dangerEvent(dangerEvent), .integrityError(integrityError),
        .valueError(valueError), .alarm(alarm),
        .stopRequest(stopRequest), .jumpToFirmware(jumpToFirmware));

    // compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: 0x%h, expected 0x%h",
                $time, seen, exp);
        end
    endtask
    task final_report;
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rq, rs);
    endtask
    // read a word and compare the masked part
    task rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        host.xfer(1'b0, a, 32'h0, rq, rs);
        check(rq & m, e);
    endtask
    task query;
        wr(OFS_CMD, dut.CMD_STATE);
    endtask

    // a hung transfer goes straight to the verdict
    always @(posedge hung)
    begin
        errors++;
        final_report;
    end

    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(OFS_STATE, 32'h0, '1);
        host.xfer(1'b0, 8'hFC, 32'h0, rq, rs);
        check({31'h0, rs}, 32'h1);
        check(rq, 32'h0);
        // one fault at a time, motor field walking through its codes
        for (int i = 0; i < 14; i++)
        begin
            @(posedge ref_clk);
            faults <= msqr_fault_t'(14'(1 << i));
            motorSelect <= 2'(i);
            query;
            rdc(OFS_STATE, fMask[i] | (32'(i % 4) << 18), '1);
        end
        // every pin level alone, aux direction and sync output with two
        for (int i = 0; i < 10; i++)
        begin
            @(posedge ref_clk);
            faults <= '0;
            motorSelect <= 2'd0;
            pins <= msqr_pins_t'(10'(1 << i));
            auxDirOut <= (i == 0);
            syncOutLevel <= (i == 1);
            repeat (2) @(posedge ref_clk);
            query;
            rdc(OFS_PINS, pMask[i] | (i == 0 ? 32'h10 : 32'h0)
                | (i == 1 ? 32'h1000 : 32'h0), '1);
        end
        // snapshot stays put while the live speed moves on
        motion.speed <= 32'h0BAD_F00D;
        motion.microSpeed <= 16'hBEEF;
        query;
        motion.speed <= 32'h1111_2222;
        motion.microSpeed <= 16'h0001;
        rdc(OFS_SPEED, 32'h0BAD_F00D, '1);
        rdc(OFS_MSPEED, 32'hBEEF, '1);
        rdc(OFS_FREE, 32'hA5, 32'hFF);
        // version answer
        wr(OFS_CMD, CMD_FW_VERSION);
        rdc(OFS_STATUS, 32'h0A01, 32'h1F01);
        rdc(OFS_CMD, CMD_FW_VERSION, '1);
        rdc(OFS_ANSWER, CMD_FW_VERSION, '1);
        rdc(OFS_ANSWER + 8'h04, 32'h5678_3412, '1);
        rdc(OFS_ANSWER + 8'h08, 32'h0114, 32'hFFFF);
        // position answer
        motion.position <= 32'h8765_4321;
        motion.microstepPart <= 16'hFEDC;
        motion.encoderCount <= 64'h0123_4567_89AB_CDEF;
        wr(OFS_CMD, CMD_POSITION);
        rdc(OFS_ANSWER + 8'h04, 32'h8765_4321, '1);
        rdc(OFS_ANSWER + 8'h08, 32'hCDEF_FEDC, '1);
        rdc(OFS_ANSWER + 8'h0C, 32'h4567_89AB, '1);
        rdc(OFS_ANSWER + 8'h10, 32'h0123, '1);
        rdc(OFS_ANSWER + 8'h14, 32'h0, '1);
        rdc(OFS_ANSWER + 8'h18, 32'h06EA, 32'hFFFF);
        // jump result for armed, missing and already running cases
        for (int k = 0; k < 3; k++)
        begin
            hasFirmware <= (k != 1);
            inFirmware <= (k == 2);
            wr(OFS_CMD, CMD_GO_FW);
            rq = (k == 0) ? dut.RESULT_OK : (k == 1) ? dut.RESULT_NO_FW
                : dut.RESULT_RUNNING;
            rdc(OFS_ANSWER + 8'h04, rq, '1);
            rdc(OFS_ANSWER + 8'h0C, rq << 8, 32'hFF_FFFF);
            @(posedge ref_clk);
            check(jumpToFirmware, k == 0);
        end
        // danger raises alarm, jump is ignored, stop clears it
        @(posedge ref_clk);
        dangerEvent <= 1'b1;
        inFirmware <= 1'b0;
        @(posedge ref_clk);
        dangerEvent <= 1'b0;
        @(posedge ref_clk);
        check(alarm, 1'b1);
        wr(OFS_CMD, CMD_GO_FW);
        rdc(OFS_STATUS, 32'h6, 32'h6);
        rdc(OFS_ANSWER + 8'h04, dut.RESULT_RUNNING, '1);
        query;
        rdc(OFS_STATE, 32'h40, 32'h40);
        wr(OFS_CMD, dut.CMD_STOP);
        @(posedge ref_clk);
        check({stopRequest, alarm}, 2'b10);
        // sticky error flags, cleared by the query that reports them
        wr(OFS_CMD, 32'h1234_5678);
        rdc(OFS_STATUS, 32'h0400, 32'h1F00);
        @(posedge ref_clk);
        integrityError <= 1'b1;
        valueError <= 1'b1;
        @(posedge ref_clk);
        integrityError <= 1'b0;
        valueError <= 1'b0;
        query;
        rdc(OFS_STATE, 32'h7, '1);
        query;
        rdc(OFS_STATE, 32'h0, '1);
        final_report;
    end
endmodule // motor_state_query_responder_bench
